// ==== common/sfm_pkg.sv ====
// constants and types shared by the descriptor map block
package sfm_pkg;

    // ----------------------------------------------------------------
    // serial command set
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_REG_RD      = 8'h65;
    localparam logic [7:0]  OP_REG_WR      = 8'h71;
    localparam logic [7:0]  OP_DESC_RD     = 8'h5a;
    localparam logic [1:0]  ADDR_BYTES_M1  = 2'h2;

    // ----------------------------------------------------------------
    // register addresses seen over the serial link
    // ----------------------------------------------------------------
    localparam logic [23:0] RA_STATUS      = 24'h000000;
    localparam logic [23:0] RA_CFG2_NV     = 24'h000003;
    localparam logic [23:0] RA_CFG2_V      = 24'h800003;
    localparam int          ERASE_FAIL_BIT = 5;
    localparam int          WAIT_LSB       = 0;
    localparam int          WAIT_W         = 4;
    localparam logic [3:0]  WAIT_RST       = 4'h8;

    // ----------------------------------------------------------------
    // descriptor bytes
    // ----------------------------------------------------------------
    localparam logic [23:0] DA_ERR_RDOP    = 24'h000175;
    localparam logic [23:0] DA_ERR_ADDR    = 24'h000176;
    localparam logic [23:0] DA_ERR_MAP     = 24'h000177;
    localparam logic [23:0] DA_WS_WROP     = 24'h000178;
    localparam logic [23:0] DA_WS_RDOP     = 24'h000179;
    localparam logic [23:0] DA_WS_ADDR     = 24'h00017a;
    localparam logic [23:0] DA_WS_MAP      = 24'h00017b;
    localparam logic [7:0]  DV_ERR_ADDR    = 8'h00;
    localparam logic [7:0]  DV_ERR_MAP     = 8'h95;
    localparam logic [7:0]  DV_WS_ADDR     = 8'h03;
    localparam logic [7:0]  DV_WS_MAP      = 8'hd0;

    // ----------------------------------------------------------------
    // software register map (byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h00;
    localparam logic [7:0]  OFS_IRQ_CLR    = 8'h04;
    localparam logic [7:0]  OFS_IRQ_EN     = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0c;
    localparam logic [7:0]  OFS_CFG2_V     = 8'h10;
    localparam logic [7:0]  OFS_CFG2_NV    = 8'h14;
    localparam int          IRQ_N          = 3;
    localparam int          EV_ERASE_FAIL  = 0;
    localparam int          EV_HOST_WR     = 1;
    localparam int          EV_DESC_RD     = 2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } sfm_rx_t;

    typedef enum logic [2:0] {
        ST_OP, ST_ADDR, ST_DUMMY, ST_RD, ST_WR, ST_SKIP
    } sfm_state_t;

endpackage : sfm_pkg

// ==== hw/sfm_spi_shift.sv ====
// serial link front end: pin synchronisers and byte shifter
`timescale 1ns/1ps
module sfm_spi_shift import sfm_pkg::*; (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       sck,
    input  wire logic       cs_n,
    input  wire logic       si,
    input  wire logic [7:0] tx_byte,
    output sfm_rx_t         rx,
    output logic            cs_active,
    output logic            so,
    output logic            so_oe_n
);
    logic       sck_m_q, sck_s_q, sck_d_q;
    logic       cs_m_q,  cs_s_q;
    logic       si_m_q,  si_s_q;
    logic [2:0] cnt_q;
    logic [6:0] sr_q;
    logic [6:0] txs_q;
    logic       rise, fall;

    // --------------------
    // synchronisers; the first stage feeds only the second
    // --------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_d_q <= 1'b0;
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            si_m_q  <= 1'b0;
            si_s_q  <= 1'b0;
        end else begin
            sck_m_q <= sck;
            sck_s_q <= sck_m_q;
            sck_d_q <= sck_s_q;
            cs_m_q  <= cs_n;
            cs_s_q  <= cs_m_q;
            si_m_q  <= si;
            si_s_q  <= si_m_q;
        end
    end

    assign rise      = sck_s_q & ~sck_d_q;
    assign fall      = ~sck_s_q & sck_d_q;
    assign cs_active = ~cs_s_q;

    // --------------------
    // receive: sample on rising edge, msb first
    // --------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_s_q) begin
            cnt_q    <= 3'h0;
            sr_q     <= 7'h00;
            rx.valid <= 1'b0;
            rx.data  <= 8'h00;
        end else begin
            rx.valid <= 1'b0;
            if (rise) begin
                cnt_q <= cnt_q + 3'h1;
                sr_q  <= {sr_q[5:0], si_s_q};
                if (cnt_q == 3'h7) begin
                    rx.valid <= 1'b1;
                    rx.data  <= {sr_q, si_s_q};
                end
            end
        end
    end

    // --------------------
    // transmit: shift on falling edge, new byte at byte boundary
    // --------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || cs_s_q) begin
            so    <= 1'b0;
            txs_q <= 7'h00;
        end else if (fall) begin
            if (cnt_q == 3'h0) begin
                so    <= tx_byte[7];
                txs_q <= tx_byte[6:0];
            end else begin
                so    <= txs_q[6];
                txs_q <= {txs_q[5:0], 1'b0};
            end
        end
    end

    // pin released while deselected
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            so_oe_n <= 1'b1;
        end else begin
            so_oe_n <= cs_s_q;
        end
    end

endmodule : sfm_spi_shift

// ==== hw/sfm_desc_map.sv ====
// descriptor map, status and wait-state registers with serial and AXI4-Lite access
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Function
// - register reads use opcode 65h, advertised
// - register writes use opcode 71h, advertised
// - erase-failure flag at register address 00h
// - erase-failure flag high means last erase failed
// - erase-failure flag sits in bit five
// - both items reached by addressed register commands
// - volatile wait-state register at 800003h
// - four-bit wait-state field, width code 10b
// - wait-state field starts at bit zero
// - wait bits not in last address byte
// - byte 17Bh gives D0h, 177h gives 95h
// - nonvolatile wait-state copy at address 03h
module sfm_desc_map import sfm_pkg::*; (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        spi_sck,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_si,
    output logic             spi_so,
    output logic             spi_so_oe_n,
    input  wire logic        erase_done,
    input  wire logic        erase_failed,
    output logic [3:0]       wait_states,
    output logic             irq
);
    sfm_rx_t          rx;
    logic             cs_active;
    logic [7:0]       tx_byte;
    sfm_state_t       st_q;
    logic [1:0]       acnt_q;
    logic [7:0]       op_q;
    logic [23:0]      addr_q;
    logic             host_wr;
    logic             desc_start;
    logic             erase_fail_q;
    logic [3:0]       wait_v_q;
    logic [3:0]       wait_nv_q;
    logic [7:0]       status_byte;
    logic [IRQ_N-1:0] irq_st_q;
    logic [IRQ_N-1:0] irq_en_q;
    logic [IRQ_N-1:0] irq_ev;
    logic [IRQ_N-1:0] irq_clr;
    logic             aw_full_q, w_full_q;
    logic [7:0]       awaddr_q;
    logic [31:0]      wdata_q;
    logic [3:0]       wstrb_q;
    logic             wr_fire;
    logic             wr_map;

    // ----------------------------------------------------------------
    // serial front end
    // ----------------------------------------------------------------
    sfm_spi_shift u_shift (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .sck       (spi_sck),
        .cs_n      (spi_cs_n),
        .si        (spi_si),
        .tx_byte   (tx_byte),
        .rx        (rx),
        .cs_active (cs_active),
        .so        (spi_so),
        .so_oe_n   (spi_so_oe_n)
    );

    // ----------------------------------------------------------------
    // descriptor contents
    // ----------------------------------------------------------------
    // constants only: no write path reaches them
    function automatic logic [7:0] desc_byte(input logic [23:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            DA_ERR_RDOP: v = OP_REG_RD;
            DA_ERR_ADDR: v = DV_ERR_ADDR;
            DA_ERR_MAP:  v = DV_ERR_MAP;
            DA_WS_WROP:  v = OP_REG_WR;
            DA_WS_RDOP:  v = OP_REG_RD;
            DA_WS_ADDR:  v = DV_WS_ADDR;
            DA_WS_MAP:   v = DV_WS_MAP;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction : desc_byte

    assign status_byte = 8'(erase_fail_q) << ERASE_FAIL_BIT;

    // ----------------------------------------------------------------
    // byte offered to the shifter for the next byte slot
    // ----------------------------------------------------------------
    always_comb begin
        tx_byte = 8'h00;
        if (op_q == OP_DESC_RD) begin
            tx_byte = desc_byte(addr_q);
        end else if (op_q == OP_REG_RD) begin
            case (addr_q)
                RA_STATUS:  tx_byte = status_byte;
                RA_CFG2_NV: tx_byte = 8'(wait_nv_q) << WAIT_LSB;
                RA_CFG2_V:  tx_byte = 8'(wait_v_q) << WAIT_LSB;
                default:    tx_byte = 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // serial command sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || !cs_active) begin
            st_q   <= ST_OP;
            acnt_q <= 2'h0;
            op_q   <= 8'h00;
            addr_q <= 24'h000000;
        end else if (rx.valid) begin
            case (st_q)
                ST_OP: begin
                    op_q   <= rx.data;
                    acnt_q <= 2'h0;
                    if (rx.data == OP_DESC_RD || rx.data == OP_REG_RD ||
                        rx.data == OP_REG_WR) begin
                        st_q <= ST_ADDR;
                    end else begin
                        st_q <= ST_SKIP;
                    end
                end
                ST_ADDR: begin
                    addr_q <= {addr_q[15:0], rx.data};
                    acnt_q <= acnt_q + 2'h1;
                    if (acnt_q == ADDR_BYTES_M1) begin
                        st_q <= (op_q == OP_REG_WR) ? ST_WR : ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    st_q <= ST_RD;
                end
                ST_RD: begin
                    // descriptor reads stream on; register reads repeat
                    if (op_q == OP_DESC_RD) begin
                        addr_q <= addr_q + 24'h000001;
                    end
                end
                ST_WR: begin
                    st_q <= ST_SKIP;
                end
                ST_SKIP: begin
                    st_q <= ST_SKIP;
                end
                default: begin
                    st_q <= ST_SKIP;
                end
            endcase
        end
    end

    assign host_wr    = rx.valid && (st_q == ST_WR);
    assign desc_start = rx.valid && (st_q == ST_DUMMY) && (op_q == OP_DESC_RD);

    // ----------------------------------------------------------------
    // erase-failure flag
    // ----------------------------------------------------------------
    // an erase result outranks a host write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            erase_fail_q <= 1'b0;
        end else if (erase_done) begin
            erase_fail_q <= erase_failed;
        end else if (host_wr && addr_q == RA_STATUS) begin
            erase_fail_q <= rx.data[ERASE_FAIL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // wait-state registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_v_q <= WAIT_RST;
        end else if (host_wr && addr_q == RA_CFG2_V) begin
            wait_v_q <= rx.data[WAIT_LSB +: WAIT_W];
        end else if (wr_fire && awaddr_q == OFS_CFG2_V && wstrb_q[0]) begin
            wait_v_q <= wdata_q[WAIT_LSB +: WAIT_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_nv_q <= WAIT_RST;
        end else if (host_wr && addr_q == RA_CFG2_NV) begin
            wait_nv_q <= rx.data[WAIT_LSB +: WAIT_W];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_states <= WAIT_RST;
        end else begin
            wait_states <= wait_v_q;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable and output
    // ----------------------------------------------------------------
    always_comb begin
        irq_ev                = '0;
        irq_ev[EV_ERASE_FAIL] = erase_done & erase_failed;
        irq_ev[EV_HOST_WR]    = host_wr;
        irq_ev[EV_DESC_RD]    = desc_start;
    end

    assign irq_clr = (wr_fire && awaddr_q == OFS_IRQ_CLR && wstrb_q[0]) ?
                     wdata_q[IRQ_N-1:0] : '0;

    // set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q <= '0;
        end else if (wr_fire && awaddr_q == OFS_IRQ_EN && wstrb_q[0]) begin
            irq_en_q <= wdata_q[IRQ_N-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_st_q & irq_en_q);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channels
    // ----------------------------------------------------------------
    assign wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
    assign wr_map  = (awaddr_q == OFS_IRQ_CLR) || (awaddr_q == OFS_IRQ_EN) ||
                     (awaddr_q == OFS_CFG2_V);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            awaddr_q      <= 8'h00;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            s_axi_awready <= ~aw_full_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q     <= 1'b0;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_fire) begin
                w_full_q <= 1'b0;
            end
            s_axi_wready <= ~w_full_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channels
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h00000000;
            case ({s_axi_araddr[7:2], 2'b00})
                OFS_IRQ_STAT: s_axi_rdata <= 32'(irq_st_q);
                OFS_IRQ_CLR:  s_axi_rdata <= 32'h00000000;
                OFS_IRQ_EN:   s_axi_rdata <= 32'(irq_en_q);
                OFS_STATUS:   s_axi_rdata <= 32'(status_byte);
                OFS_CFG2_V:   s_axi_rdata <= 32'(wait_v_q);
                OFS_CFG2_NV:  s_axi_rdata <= 32'(wait_nv_q);
                default:      s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : sfm_desc_map

// ==== verification/sfm_desc_map_props.sv ====
// concurrent checks on the descriptor map ports
`timescale 1ns/1ps
module sfm_desc_map_props import sfm_pkg::*; (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        spi_cs_n,
    input wire logic        spi_so_oe_n,
    input wire logic        erase_done,
    input wire logic [3:0]  wait_states,
    input wire logic        irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // --------------------
    // bus answers
    // --------------------
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_unmapped_zero: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    // --------------------
    // serial side and side effects
    // --------------------
    a_out_idle: assert property (spi_cs_n [*5] |-> spi_so_oe_n)
        else $error("out driven while idle");
    // moves only on a serial frame or bus write
    a_wait_cause: assert property (
        $changed(wait_states) |-> !spi_cs_n || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("wait field moved without a write");
    a_irq_cause: assert property ($rose(irq) |-> !spi_cs_n || s_axi_bvalid ||
        $past(s_axi_bvalid) || $past(erase_done, 2))
        else $error("interrupt rose without cause");
    c_erase_irq: cover property (erase_done ##2 irq);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_serial_wait: cover property ($changed(wait_states) && !spi_cs_n);
endmodule : sfm_desc_map_props

bind sfm_desc_map sfm_desc_map_props u_props (.*);

// ==== verification/sfm_host_model.sv ====
// behavioural serial host that clocks command frames into the block
`timescale 1ns/1ps
module sfm_host_model (
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    input  wire logic spi_so,
    input  wire logic spi_so_oe_n
);
    localparam int HALF_NS = 160;
    logic [7:0] mosi [$];
    logic [7:0] miso [$];
    initial begin
        spi_sck  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
    end
    // --------------------
    // one frame, msb first; the clock stands still between frames
    // --------------------
    task frame(input int nb);
        logic [7:0] o, i;
        miso.delete();
        // off the aclk grid
        #13;
        spi_cs_n = 1'b0;
        for (int b = 0; b < nb; b++) begin
            o = (b < mosi.size()) ? mosi[b] : 8'h00;
            for (int k = 7; k >= 0; k--) begin
                spi_si = o[k];
                #(HALF_NS);
                spi_sck = 1'b1;
                i[k] = spi_so_oe_n ? 1'b1 : spi_so;
                #(HALF_NS);
                spi_sck = 1'b0;
            end
            miso.push_back(i);
        end
        #(HALF_NS);
        spi_cs_n = 1'b1;
        // released line must not look held at its last value
        spi_si = ~spi_si;
        #(HALF_NS);
    endtask : frame
endmodule : sfm_host_model

// ==== verification/sfm_desc_map_test.sv ====
// self-checking bench for the descriptor map block
`timescale 1ns/1ps
module sfm_desc_map_test import sfm_pkg::*;;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        erase_done    = 1'b0;
    logic        erase_failed  = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic        spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [3:0]  wait_states, v;
    int          bad_count = 0, num_checks = 0, cycles = 0, seed = 32'hec11;

    sfm_desc_map DUT (.*);
    sfm_host_model host (.*);

    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // --------------------
    // checking and bus tasks
    // --------------------
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
        bit aw, w;
        {aw, w} = 2'b00;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd
    task ser(input logic [7:0] op, input logic [23:0] a, input logic [7:0] b, input int nb);
        host.mosi = '{op, a[23:16], a[15:8], a[7:0], b};
        host.frame(nb);
    endtask : ser
    // irq settles a few cycles after the answer
    task irq_step(input logic [7:0] a, input logic [31:0] wd, input logic e);
        axi_wr(a, wd, r);
        repeat (3) @(posedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_step
    // descriptor bytes; the two map bytes built field by field
    function automatic logic [7:0] desc_exp(input logic [23:0] a);
        case (a)
            24'h000175, 24'h000179: return 8'h65;
            24'h000178: return 8'h71;
            24'h00017a: return 8'h03;
            24'h000177: return {1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 3'h5};
            24'h00017b: return {1'h1, 2'h2, 1'h1, 1'h0, 3'h0};
            default: return 8'h00;
        endcase
    endfunction : desc_exp
    task desc_check(input logic [23:0] base);
        ser(OP_DESC_RD, base, 8'h00, 14);
        for (int i = 0; i < 9; i++) begin
            chk("desc", {24'h0, desc_exp(base + 24'(i))}, {24'h0, host.miso[5 + i]});
        end
    endtask : desc_check
    // --------------------
    // scenarios
    // --------------------
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        desc_check(DA_ERR_RDOP);
        desc_check(DA_ERR_MAP);
        $display("descriptor test done");
        axi_wr(OFS_IRQ_EN, 32'h1, r);
        for (int k = 0; k < 4; k++) begin
            v = (k < 2) ? {3'h0, ~k[0]} : 4'($random(seed));
            @(posedge aclk);
            erase_done   <= 1'b1;
            erase_failed <= v[0];
            @(posedge aclk);
            erase_done   <= 1'b0;
            ser(OP_REG_RD, RA_STATUS, 8'h00, 6);
            chk("erase bit", {31'h0, v[0]}, {31'h0, host.miso[5][ERASE_FAIL_BIT]});
            axi_rd(OFS_STATUS, d, r);
            chk("status reg", {31'h0, v[0]}, {31'h0, d[ERASE_FAIL_BIT]});
        end
        chk("irq raised", 32'h1, {31'h0, irq});
        irq_step(OFS_IRQ_EN, 32'h0, 1'b0);
        irq_step(OFS_IRQ_EN, 32'h1, 1'b1);
        irq_step(OFS_IRQ_CLR, 32'h1, 1'b0);
        $display("erase flag test done");
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 4'hf : 4'($random(seed));
            ser(OP_REG_WR, RA_CFG2_V, {4'h0, v}, 5);
            chk("serial wait", {28'h0, v}, {28'h0, wait_states});
            ser(OP_REG_RD, RA_CFG2_V, 8'h00, 6);
            chk("wait read", {28'h0, v}, {28'h0, host.miso[5][3:0]});
            v = 4'($random(seed));
            axi_wr(OFS_CFG2_V, {28'h0, v}, r);
            repeat (2) @(posedge aclk);
            chk("bus wait", {28'h0, v}, {28'h0, wait_states});
        end
        ser(OP_REG_RD, RA_CFG2_NV, 8'h00, 6);
        chk("nv wait", {28'h0, WAIT_RST}, {28'h0, host.miso[5][3:0]});
        ser(OP_REG_WR, RA_CFG2_NV, 8'h05, 5);
        axi_wr(OFS_CFG2_NV, 32'h3, r);
        chk("ro bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        ser(OP_REG_RD, RA_CFG2_NV, 8'h00, 6);
        chk("nv write", 32'h5, {28'h0, host.miso[5][3:0]});
        axi_rd(8'h40, d, r);
        chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, d);
        $display("wait field test done");
        desc_check(DA_ERR_RDOP);
        $display("constancy test done");
        report_and_stop();
    end
endmodule : sfm_desc_map_test
